// File: inc/fault_irq_pkg.sv
// Constants, register map and state types for the supervisory fault, interrupt and temperature block
package fault_irq_pkg;
  // ****************************************************
  // Timing
  // ****************************************************
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned RECHECK_US = 32;
  localparam int unsigned RECHECK_CYC = RECHECK_US * CLK_MHZ;
  localparam int unsigned PULSE_US = 6;
  localparam int unsigned PULSE_CYC = PULSE_US * CLK_MHZ;
  localparam int unsigned SETTLE_US = 250;
  localparam int unsigned SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam longint unsigned AUTO_PERIOD_S = 60;
  localparam longint unsigned AUTO_CYC = AUTO_PERIOD_S * 64'(CLK_MHZ) * 64'd1000000;
  localparam int unsigned SHUT_STEP_US = 1;
  localparam int unsigned SHUT_STEP_CYC = SHUT_STEP_US * CLK_MHZ;
  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [3:0] ADDR_MASK_A = 4'h0;
  localparam logic [3:0] ADDR_MASK_B = 4'h1;
  localparam logic [3:0] ADDR_FLAGS_A = 4'h2;
  localparam logic [3:0] ADDR_FLAGS_B = 4'h3;
  localparam logic [3:0] ADDR_THERMAL_SETUP = 4'h4;
  localparam logic [3:0] ADDR_TEMPERATURE = 4'h5;
  localparam logic [3:0] ADDR_BIAS_CODE = 4'h6;
  localparam logic [3:0] ADDR_NEG_RAIL_ADJUST = 4'h7;
  localparam logic [3:0] ADDR_POS_RAIL_ADJUST = 4'h8;
  localparam int TRIG_BIT = 0;
  localparam int DONE_BIT = 1;
  localparam int EOC_BIT = 4;
  localparam int SRC_SEL_BIT = 7;
  localparam logic [3:0] MASK_A_RST = 4'hF;
  localparam logic [4:0] MASK_B_RST = 5'h1F;
  localparam logic [7:0] BIAS_CODE_RST = 8'h74;
  localparam logic [7:0] NEG_ADJ_RST = 8'h80;
  localparam logic [2:0] POS_SET_RST = 3'h2;
  localparam logic [7:0] TEMP_MIN = 8'hF6;
  localparam logic [7:0] TEMP_MAX = 8'h55;
  // ****************************************************
  // States
  // ****************************************************
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_SHUTDOWN = 2'b01,
    ST_STANDBY = 2'b11
  } pwr_state_e;
  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_SETTLE = 2'b01,
    TS_CONVERT = 2'b11
  } therm_state_e;
endpackage

// File: src/fault_irq_and_temp_readout.sv
// Fault response, interrupt flags, power-good and temperature acquisition sequencer
`timescale 1ns/100ps
module fault_irq_and_temp_readout #(
  parameter int unsigned SETTLE_CYC = fault_irq_pkg::SETTLE_CYC,
  parameter int unsigned AUTO_CYC = 32'(fault_irq_pkg::AUTO_CYC)
) (
  input wire logic ref_clk, // 50 MHz clock
  input wire logic reset, // Async reset, active high
  input wire logic auto_variant, // 1: auto-acquisition variant
  input wire logic overheat_shutdown, // Die overheat fault
  input wire logic pos_boost_undervolt, // Positive boost undervoltage
  input wire logic inv_converter_undervolt, // Inverting converter undervoltage
  input wire logic input_low_lockout, // Input undervoltage lockout
  input wire logic neg_ldo_undervolt, // Negative LDO undervoltage
  input wire logic pos_ldo_undervolt, // Positive LDO undervoltage
  input wire logic neg_pump_undervolt, // Negative pump undervoltage
  input wire logic pos_pump_undervolt, // Positive pump undervoltage
  input wire logic [3:0] rail_enable_pins, // Rail enables: neg LDO, neg pump, pos LDO, pos pump
  input wire logic [3:0] rail_in_reg, // Per-rail regulation status
  input wire logic [3:0] reg_addr, // Register index
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, valid cycle after strobe
  output logic [3:0] rail_on, // Rail enable to regulators
  output logic converters_on, // Boost and inverting converters enable
  output logic standby, // Device in standby
  output logic rails_ok_out_o, // Power-good drive level, always 0
  output logic rails_ok_out_oe, // Power-good pull-down enable
  output logic irq_out_n_o, // Interrupt drive level, always 0
  output logic irq_out_n_oe, // Interrupt pull-down enable
  output logic ntc_bias_en, // Thermistor bias and converter enable
  output logic adc_start, // Conversion start pulse
  input wire logic adc_done, // Conversion complete pulse
  input wire logic signed [9:0] adc_celsius, // Raw reading, whole degrees
  output logic [7:0] bias_code_out, // Backplane bias code
  output logic external_bias_sel, // 1: bias from external adjust input
  output logic [7:0] neg_rail_level, // Negative rail adjust value
  output logic [2:0] pos_rail_setting // Positive rail setting
);
  import fault_irq_pkg::*;

  if (SETTLE_CYC < 1 || SETTLE_CYC > 65535 || AUTO_CYC <= SETTLE_CYC) begin : g_chk
    $error("settle or auto period out of range");
  end

  function automatic logic [7:0] saturate(input logic signed [9:0] t);
    if (t < -10'sd10) begin
      return TEMP_MIN;
    end else if (t > 10'sd85) begin
      return TEMP_MAX;
    end
    return t[7:0];
  endfunction

  function automatic logic [1:0] top_bit(input logic [3:0] v);
    logic [1:0] r;
    r = 2'd0;
    for (int i = 0; i < 4; i++) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  // ****************************************************
  // Fault flags, masks and rails
  // ****************************************************
  logic [3:0] fault_a;
  logic [3:0] fault_b;
  logic [3:0] kill;
  logic done_ev;
  logic auto_done;
  pwr_state_e state_q, state_d;
  logic [3:0] mask_a_q, mask_a_d, flags_a_q, flags_a_d, fa_prev_q, fa_prev_d;
  logic [4:0] mask_b_q, mask_b_d, flags_b_q, flags_b_d;
  logic [3:0] fb_prev_q, fb_prev_d, pin_prev_q, pin_prev_d;
  logic [3:0] rail_req_q, rail_req_d, lock_q, lock_d;
  logic [10:0] hold_a_q, hold_a_d, hold_b_q, hold_b_d;
  logic [7:0] step_q, step_d;
  logic [8:0] pulse_q, pulse_d;
  logic need_read_q, need_read_d;
  logic [7:0] bias_q, bias_d, neg_adj_q, neg_adj_d, rdata_q, rdata_d;
  logic [2:0] pos_set_q, pos_set_d;
  logic trig_q, trig_d;
  logic [7:0] temp_q;
  therm_state_e tstate_q;

  assign fault_a = {input_low_lockout, inv_converter_undervolt, pos_boost_undervolt,
                    overheat_shutdown};
  assign fault_b = {pos_pump_undervolt, neg_pump_undervolt, pos_ldo_undervolt, neg_ldo_undervolt};
  // Positive LDO depends on the negative LDO
  assign kill = {fault_b[3], fault_b[1] | fault_b[0], fault_b[2], fault_b[0]};

  always_comb begin
    logic rd_a;
    logic rd_b;
    logic rel;
    rd_a = reg_rd && reg_addr == ADDR_FLAGS_A;
    rd_b = reg_rd && reg_addr == ADDR_FLAGS_B;
    rel = 1'b0;
    state_d = state_q;
    mask_a_d = mask_a_q;
    mask_b_d = mask_b_q;
    fa_prev_d = fault_a;
    fb_prev_d = fault_b;
    pin_prev_d = rail_enable_pins;
    rail_req_d = rail_req_q;
    step_d = step_q;
    pulse_d = pulse_q;
    bias_d = bias_q;
    neg_adj_d = neg_adj_q;
    pos_set_d = pos_set_q;
    rdata_d = rdata_q;
    hold_a_d = (hold_a_q != 11'd0) ? hold_a_q - 11'd1 : hold_a_q;
    hold_b_d = (hold_b_q != 11'd0) ? hold_b_q - 11'd1 : hold_b_q;
    need_read_d = need_read_q;
    flags_a_d = flags_a_q;
    flags_b_d = flags_b_q;
    // Read clears the register and holds off level re-flagging for the recheck time
    if (rd_a) begin
      flags_a_d = 4'h0;
      hold_a_d = 11'(RECHECK_CYC);
      need_read_d = 1'b0;
    end
    if (rd_b) begin
      flags_b_d = 5'h00;
      hold_b_d = 11'(RECHECK_CYC);
      need_read_d = 1'b0;
    end
    if (pulse_q != 9'd0) begin
      pulse_d = pulse_q - 9'd1;
      if (pulse_q == 9'd1) begin
        flags_b_d[EOC_BIT] = 1'b0;
      end
    end
    // Set wins over clear: new edges always, persisting level after hold-off
    flags_a_d = flags_a_d | (fault_a & ~fa_prev_q)
                | ((hold_a_q == 11'd0 && !rd_a) ? fault_a : 4'h0);
    flags_b_d[3:0] = flags_b_d[3:0] | (fault_b & ~fb_prev_q)
                     | ((hold_b_q == 11'd0 && !rd_b) ? fault_b : 4'h0);
    if (done_ev) begin
      flags_b_d[EOC_BIT] = 1'b1;
      if (auto_done) begin
        pulse_d = 9'(PULSE_CYC);
      end
    end
    if ((|fault_a) || (|fault_b)) begin
      need_read_d = 1'b1;
    end
    rel = auto_variant || !need_read_d;
    // Rail enables act on edges only, so a faulted rail needs a fresh rising edge
    for (int i = 0; i < 4; i++) begin
      if (!rail_enable_pins[i] && pin_prev_q[i]) begin
        rail_req_d[i] = 1'b0;
      end else if (rail_enable_pins[i] && !pin_prev_q[i] && !lock_q[i]
                   && state_q != ST_SHUTDOWN) begin
        rail_req_d[i] = 1'b1;
      end
    end
    lock_d = (lock_q & ~{4{rel}}) | (lock_q & kill) | kill;
    rail_req_d = rail_req_d & ~kill;
    case (state_q)
      ST_ACTIVE: begin
        if (|fault_a) begin
          state_d = ST_SHUTDOWN;
          step_d = 8'(SHUT_STEP_CYC);
        end
      end
      ST_SHUTDOWN: begin
        if (step_q != 8'd0) begin
          step_d = step_q - 8'd1;
        end else if (rail_req_q == 4'h0) begin
          state_d = ST_STANDBY;
        end else begin
          rail_req_d[top_bit(rail_req_q)] = 1'b0;
          step_d = 8'(SHUT_STEP_CYC);
        end
      end
      ST_STANDBY: begin
        if (fault_a != 4'h0 || !rel) begin
          lock_d = 4'hF;
          rail_req_d = 4'h0;
        end else if (|(rail_enable_pins & ~pin_prev_q)) begin
          state_d = ST_ACTIVE;
        end else begin
          rail_req_d = 4'h0;
        end
      end
      default: state_d = ST_STANDBY;
    endcase
    if (reg_wr) begin
      case (reg_addr)
        ADDR_MASK_A: mask_a_d = reg_wdata[3:0];
        ADDR_MASK_B: mask_b_d = reg_wdata[4:0];
        ADDR_BIAS_CODE: bias_d = reg_wdata;
        ADDR_NEG_RAIL_ADJUST: neg_adj_d = reg_wdata;
        ADDR_POS_RAIL_ADJUST: pos_set_d = reg_wdata[2:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_MASK_A: rdata_d = {4'h0, mask_a_q};
        ADDR_MASK_B: rdata_d = {3'h0, mask_b_q};
        ADDR_FLAGS_A: rdata_d = {4'h0, flags_a_q};
        ADDR_FLAGS_B: rdata_d = {3'h0, flags_b_q};
        ADDR_THERMAL_SETUP: rdata_d = {6'h00, tstate_q == TS_IDLE, trig_q};
        ADDR_TEMPERATURE: rdata_d = temp_q;
        ADDR_BIAS_CODE: rdata_d = bias_q;
        ADDR_NEG_RAIL_ADJUST: rdata_d = neg_adj_q;
        ADDR_POS_RAIL_ADJUST: rdata_d = {5'h00, pos_set_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_STANDBY;
      mask_a_q <= MASK_A_RST;
      mask_b_q <= MASK_B_RST;
      flags_a_q <= 4'h0;
      flags_b_q <= 5'h00;
      fa_prev_q <= 4'h0;
      fb_prev_q <= 4'h0;
      pin_prev_q <= 4'h0;
      rail_req_q <= 4'h0;
      lock_q <= 4'h0;
      hold_a_q <= 11'd0;
      hold_b_q <= 11'd0;
      step_q <= 8'd0;
      pulse_q <= 9'd0;
      need_read_q <= 1'b0;
      bias_q <= BIAS_CODE_RST;
      neg_adj_q <= NEG_ADJ_RST;
      pos_set_q <= POS_SET_RST;
      rdata_q <= 8'h00;
    end else begin
      state_q <= state_d;
      mask_a_q <= mask_a_d;
      mask_b_q <= mask_b_d;
      flags_a_q <= flags_a_d;
      flags_b_q <= flags_b_d;
      fa_prev_q <= fa_prev_d;
      fb_prev_q <= fb_prev_d;
      pin_prev_q <= pin_prev_d;
      rail_req_q <= rail_req_d;
      lock_q <= lock_d;
      hold_a_q <= hold_a_d;
      hold_b_q <= hold_b_d;
      step_q <= step_d;
      pulse_q <= pulse_d;
      need_read_q <= need_read_d;
      bias_q <= bias_d;
      neg_adj_q <= neg_adj_d;
      pos_set_q <= pos_set_d;
      rdata_q <= rdata_d;
    end
  end

  assign converters_on = state_q != ST_STANDBY;
  assign standby = state_q == ST_STANDBY;
  assign rail_on = rail_req_q & ~lock_q & {4{converters_on}};
  assign rails_ok_out_o = 1'b0;
  assign rails_ok_out_oe = !((&rail_on) && (&rail_in_reg) && fault_a == 4'h0
                             && fault_b == 4'h0);
  assign irq_out_n_o = 1'b0;
  assign irq_out_n_oe = (|(flags_a_q & mask_a_q)) || (|(flags_b_q & mask_b_q));
  assign reg_rdata = rdata_q;
  assign bias_code_out = bias_q;
  assign external_bias_sel = !neg_adj_q[SRC_SEL_BIT];
  assign neg_rail_level = neg_adj_q;
  assign pos_rail_setting = pos_set_q;

  // ****************************************************
  // Temperature acquisition
  // ****************************************************
  therm_state_e tstate_d;
  logic trig_set;
  logic [15:0] tcnt_q, tcnt_d;
  logic [31:0] auto_q, auto_d;
  logic auto_run_q, auto_run_d, start_q, start_d;
  logic [7:0] temp_d;

  assign trig_set = reg_wr && reg_addr == ADDR_THERMAL_SETUP && reg_wdata[TRIG_BIT];
  assign done_ev = tstate_q == TS_CONVERT && adc_done;
  assign auto_done = done_ev && auto_run_q;

  always_comb begin
    tstate_d = tstate_q;
    tcnt_d = tcnt_q;
    auto_run_d = auto_run_q;
    temp_d = temp_q;
    start_d = 1'b0;
    trig_d = trig_q | trig_set;
    auto_d = auto_variant ? ((auto_q == 32'd0) ? 32'(AUTO_CYC - 1) : auto_q - 32'd1) : 32'd0;
    case (tstate_q)
      TS_IDLE: begin
        if (trig_d || (auto_variant && auto_q == 32'd0)) begin
          tstate_d = TS_SETTLE;
          tcnt_d = 16'(SETTLE_CYC - 1);
          auto_run_d = !trig_d;
        end
      end
      TS_SETTLE: begin
        if (tcnt_q == 16'd0) begin
          tstate_d = TS_CONVERT;
          start_d = 1'b1;
        end else begin
          tcnt_d = tcnt_q - 16'd1;
        end
      end
      TS_CONVERT: begin
        if (trig_set) begin
          auto_run_d = 1'b0;
        end
        if (adc_done) begin
          tstate_d = TS_IDLE;
          temp_d = saturate(adc_celsius);
          trig_d = 1'b0;
        end
      end
      default: tstate_d = TS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tstate_q <= TS_IDLE;
      tcnt_q <= 16'd0;
      auto_q <= 32'd0;
      auto_run_q <= 1'b0;
      start_q <= 1'b0;
      trig_q <= 1'b0;
      temp_q <= 8'h00;
    end else begin
      tstate_q <= tstate_d;
      tcnt_q <= tcnt_d;
      auto_q <= auto_d;
      auto_run_q <= auto_run_d;
      start_q <= start_d;
      trig_q <= trig_d;
      temp_q <= temp_d;
    end
  end

  assign ntc_bias_en = tstate_q != TS_IDLE;
  assign adc_start = start_q;

  // ****************************************************
  // Checks
  // ****************************************************
  localparam int RECHK_MAX = RECHECK_CYC + 1;
  localparam int PULSE_MAX = PULSE_CYC + 1;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_core_fault_leaves: assert property (|fault_a |=> state_q != ST_ACTIVE)
    else $error("core fault did not start shutdown");
  a_standby_rails_off: assert property (state_q == ST_STANDBY |-> rail_on == 4'h0)
    else $error("rail on in standby");
  a_fault_flags_set: assert property ($rose(fault_a[0]) |-> rails_ok_out_oe ##1 flags_a_q[0])
    else $error("fault flag not set");
  a_rail_dependent: assert property (fault_b[0] |=> !rail_on[0] && !rail_on[2])
    else $error("dependent rail still on");
  a_pgood_release: assert property (!rails_ok_out_oe |-> &rail_on && &rail_in_reg)
    else $error("power good released early");
  a_read_clears: assert property (reg_rd && reg_addr == ADDR_FLAGS_A && fault_a == 4'h0
    |=> flags_a_q == 4'h0)
    else $error("read did not clear flags");
  // Cycles that a persisting overheat fault has gone without its flag
  logic [10:0] refl_cnt_q, refl_cnt_d;
  always_comb begin
    refl_cnt_d = (fault_a[0] && !flags_a_q[0]) ? refl_cnt_q + 11'd1 : 11'd0;
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      refl_cnt_q <= 11'd0;
    end else begin
      refl_cnt_q <= refl_cnt_d;
    end
  end
  a_refault_time: assert property (refl_cnt_q <= 11'(RECHK_MAX))
    else $error("persisting fault not re-flagged");
  a_temp_range: assert property ($signed(temp_q) >= -8'sd10 && $signed(temp_q) <= 8'sd85)
    else $error("temperature out of range");
  a_settle_wait: assert property ($rose(ntc_bias_en) |-> !adc_start [*8])
    else $error("conversion started before settling");
  a_done_effects: assert property (done_ev |=> !trig_q && flags_b_q[EOC_BIT]
    && $past(tstate_q) == TS_CONVERT)
    else $error("end of conversion effects missing");
  a_auto_pulse: assert property (auto_done && !trig_set |=> ##[1:PULSE_MAX] !flags_b_q[EOC_BIT])
    else $error("auto end flag did not clear");

  c_shutdown: cover property (state_q == ST_SHUTDOWN ##[1:400] state_q == ST_STANDBY);
  c_auto_conv: cover property (auto_done);
  c_host_conv: cover property (done_ev && !auto_run_q);
  c_rail_fault: cover property (state_q == ST_ACTIVE && |kill);
endmodule

// File: dv/analog_front_model.sv
// Stand-in for the thermistor converter and the rail regulators
`timescale 1ns/100ps
module analog_front_model #(
  parameter int unsigned CONV_CYC = 8
) (
  input wire logic ref_clk, // 50 MHz clock
  input wire logic adc_start, // Conversion start pulse
  input wire logic signed [9:0] temp_now, // Temperature to report
  output logic adc_done, // Conversion complete pulse
  output logic signed [9:0] adc_celsius, // Reading, valid only with done
  input wire logic [3:0] rail_on, // Rail enables from the block
  output logic [3:0] rail_in_reg // Per-rail regulation status
);
  int cnt;
  logic [3:0] ramp_q;
  initial begin
    cnt = 0;
    ramp_q = 4'h0;
    adc_done = 1'b0;
    adc_celsius = 10'h155;
    rail_in_reg = 4'h0;
  end
  // ****************************************************
  // Converter and regulators
  // ****************************************************
  always @(posedge ref_clk) begin
    adc_done <= !adc_start && cnt == 1;
    // Reading is not held outside done
    adc_celsius <= (!adc_start && cnt == 1) ? temp_now : ~adc_celsius;
    if (adc_start) begin
      cnt <= CONV_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    ramp_q <= rail_on;
    rail_in_reg <= ramp_q & rail_on; // Regulation lags the enable
  end
endmodule

// File: dv/tb_top.sv
// Self-checking testbench for the fault, interrupt and temperature block
`timescale 1ns/100ps
module tb_top;
  import fault_irq_pkg::*;
  localparam int unsigned SETTLE = 20;
  localparam int unsigned AUTO = 1000;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic auto_variant = 1'b0;
  logic [3:0] core_flt = 4'h0;
  logic [3:0] rail_flt = 4'h0;
  logic [3:0] pins = 4'h0;
  logic [3:0] addr = 4'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic signed [9:0] temp_set = 10'sd25;
  logic [7:0] rdata, bias_out, neg_lvl;
  logic [3:0] rail_on, in_reg;
  logic conv_on, stby, ok_o, ok_oe, irq_o, irq_oe, bias_en, start, done, ext_sel, bad;
  logic signed [9:0] celsius;
  logic [2:0] pos_set;
  int fails = 0;
  int checks = 0;
  int n;
  int steps;
  logic [3:0] pr;
  fault_irq_and_temp_readout #(.SETTLE_CYC(SETTLE), .AUTO_CYC(AUTO)) dut (
    .ref_clk(ref_clk), .reset(reset), .auto_variant(auto_variant),
    .overheat_shutdown(core_flt[0]), .pos_boost_undervolt(core_flt[1]),
    .inv_converter_undervolt(core_flt[2]), .input_low_lockout(core_flt[3]),
    .neg_ldo_undervolt(rail_flt[0]), .pos_ldo_undervolt(rail_flt[1]),
    .neg_pump_undervolt(rail_flt[2]), .pos_pump_undervolt(rail_flt[3]),
    .rail_enable_pins(pins), .rail_in_reg(in_reg), .reg_addr(addr), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .rail_on(rail_on),
    .converters_on(conv_on), .standby(stby), .rails_ok_out_o(ok_o),
    .rails_ok_out_oe(ok_oe), .irq_out_n_o(irq_o), .irq_out_n_oe(irq_oe),
    .ntc_bias_en(bias_en), .adc_start(start), .adc_done(done), .adc_celsius(celsius),
    .bias_code_out(bias_out), .external_bias_sel(ext_sel), .neg_rail_level(neg_lvl),
    .pos_rail_setting(pos_set));
  analog_front_model afe (.ref_clk(ref_clk), .adc_start(start), .temp_now(temp_set),
    .adc_done(done), .adc_celsius(celsius), .rail_on(rail_on), .rail_in_reg(in_reg));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // ****************************************************
  // Access and checking tasks
  // ****************************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic expect_reg(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask
  function automatic logic sel(input int which);
    case (which)
      0: return irq_oe;
      1: return stby;
      2: return bias_en;
      default: return start;
    endcase
  endfunction
  task automatic wait_sig(input int which, input logic lvl, input int lim);
    n = 0;
    while (sel(which) !== lvl && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("wait in time", 8'(n < lim), 8'h01);
  endtask
  task automatic toggle(input logic [3:0] m);
    @(posedge ref_clk);
    pins <= pins & ~m;
    repeat (2) @(posedge ref_clk);
    pins <= pins | m;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic rails_up();
    toggle(4'hF);
    check("rails up", {4'h0, rail_on}, 8'h0F);
    check("power good oe", {7'h0, ok_oe}, 8'h00);
  endtask
  task automatic convert(input logic signed [9:0] t, input logic [7:0] exp, input bit masked);
    temp_set = t;
    reg_write(ADDR_THERMAL_SETUP, 8'h01);
    @(posedge ref_clk);
    #1;
    check("bias enable", {7'h0, bias_en}, 8'h01);
    wait_sig(3, 1'b1, SETTLE + 4);
    check("settle time", 8'(n >= SETTLE - 1 && n <= SETTLE + 1), 8'h01);
    expect_reg("done low", ADDR_THERMAL_SETUP, 8'h01);
    wait_sig(2, 1'b0, 40);
    #20;
    check("eoc irq", {7'h0, irq_oe}, {7'h0, !masked});
    expect_reg("trigger cleared", ADDR_THERMAL_SETUP, 8'h02);
    expect_reg("eoc flag", ADDR_FLAGS_B, 8'h10);
    check("irq released", {7'h0, irq_oe}, 8'h00);
    expect_reg("temperature", ADDR_TEMPERATURE, exp);
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    print_verdict();
  end
  // ****************************************************
  // Tests
  // ****************************************************
  initial begin
    logic [3:0] ra [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'hF};
    logic [7:0] rv [8] = '{8'h0F, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h74, 8'h80, 8'h00};
    logic signed [9:0] tin [5] = '{-10'sd20, -10'sd10, 10'sd25, 10'sd85, 10'sd100};
    logic [7:0] tout [5] = '{8'hF6, 8'hF6, 8'h19, 8'h55, 8'h55};
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) expect_reg("reset value", ra[i], rv[i]);
    check("standby", {7'h0, stby}, 8'h01);
    check("reset outputs", {2'h0, ok_o, irq_o, conv_on, ok_oe, irq_oe, bias_en}, 8'h04);
    check("internal bias", {7'h0, ext_sel}, 8'h00);
    check("pos setting", {5'h0, pos_set}, 8'h02);
    $display("test reset done");
    for (int i = 0; i < 5; i++) convert(tin[i], tout[i], 1'b0);
    reg_write(ADDR_MASK_B, 8'h0F);
    convert(10'sd1, 8'h01, 1'b1);
    reg_write(ADDR_MASK_B, 8'h1F);
    $display("test temperature done");
    reg_write(ADDR_NEG_RAIL_ADJUST, 8'h00);
    reg_write(ADDR_BIAS_CODE, 8'h75);
    @(posedge ref_clk);
    #1;
    check("external bias", {7'h0, ext_sel}, 8'h01);
    check("neg level", neg_lvl, 8'h00);
    check("bias code", bias_out, 8'h75);
    reg_write(ADDR_NEG_RAIL_ADJUST, 8'h80);
    $display("test bias done");
    rails_up();
    @(posedge ref_clk);
    rail_flt[0] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    check("rail drop", {4'h0, rail_on}, 8'h0A);
    check("converters", {7'h0, conv_on}, 8'h01);
    check("pg low", {6'h0, ok_oe, irq_oe}, 8'h03);
    @(posedge ref_clk);
    rail_flt[0] <= 1'b0;
    toggle(4'h5);
    check("locked", {4'h0, rail_on}, 8'h0A);
    expect_reg("rail flag", ADDR_FLAGS_B, 8'h01);
    toggle(4'h5);
    check("re-enabled", {4'h0, rail_on}, 8'h0F);
    $display("test rail fault done");
    @(posedge ref_clk);
    core_flt[0] <= 1'b1;
    bad = 1'b0;
    n = 0;
    steps = 0;
    pr = 4'hF;
    while (stby !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (!(rail_on inside {4'hF, 4'h7, 4'h3, 4'h1, 4'h0})) bad = 1'b1;
      if (rail_on !== pr) steps++;
      pr = rail_on;
    end
    check("shutdown order", {7'h0, bad}, 8'h00);
    check("shutdown steps", 8'(steps), 8'h04);
    check("standby time", {7'h0, stby}, 8'h01);
    check("all off", {2'h0, rail_on, ok_oe, irq_oe}, 8'h03);
    expect_reg("core flag", ADDR_FLAGS_A, 8'h01);
    check("irq cleared", {7'h0, irq_oe}, 8'h00);
    wait_sig(0, 1'b1, 1602);
    @(posedge ref_clk);
    core_flt[0] <= 1'b0;
    expect_reg("core reflag", ADDR_FLAGS_A, 8'h01);
    $display("test core fault done");
    @(posedge ref_clk);
    auto_variant <= 1'b1;
    wait_sig(2, 1'b1, AUTO + 30);
    wait_sig(0, 1'b1, SETTLE + 40);
    wait_sig(0, 1'b0, 400);
    check("pulse width", 8'(n >= PULSE_CYC - 2 && n <= PULSE_CYC + 2), 8'h01);
    convert(-10'sd1, 8'hFF, 1'b0);
    rails_up();
    @(posedge ref_clk);
    rail_flt[2] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    check("pump drop", {4'h0, rail_on}, 8'h0D);
    @(posedge ref_clk);
    rail_flt[2] <= 1'b0;
    toggle(4'h2);
    check("auto re-enable", {4'h0, rail_on}, 8'h0F);
    $display("test auto variant done");
    print_verdict();
  end
endmodule
